// ===== logic/fsspc_pkg.sv
// Constants and carrier types of the flash security and protection commands
package fsspc_pkg;
  // Command opcodes
  localparam logic [7:0] CMD_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] CMD_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_READ_CONFIG = 8'h35;
  localparam logic [7:0] CMD_WRITE_CONFIG = 8'h01;
  localparam logic [7:0] CMD_READ_PROTECT_MAP = 8'h72;
  localparam logic [7:0] CMD_WRITE_PROTECT_MAP = 8'h42;
  localparam logic [7:0] CMD_FREEZE_PROTECT_MAP = 8'h8D;
  localparam logic [7:0] CMD_NONVOLATILE_LOCK_FREEZE = 8'hE8;
  localparam logic [7:0] CMD_PROGRAM_IDENTIFIER = 8'hA5;
  localparam logic [7:0] CMD_LOCKOUT_IDENTIFIER = 8'h85;

  // Register layouts
  localparam int unsigned MAP_W = 144;
  localparam logic [11:0] MAP_BYTES = 12'h012;
  localparam int unsigned STAT_W = 8;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_WEL_BIT = 1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [MAP_W-1:0] MAP_RESET = '0;
  localparam logic [11:0] CFG_DATA_BYTES = 12'h002;

  // Identifier space
  localparam int unsigned SID_ADDR_W = 11;
  localparam int unsigned SID_BYTES = 2048;
  localparam int unsigned PAGE_BYTES = 256;
  localparam logic [15:0] SID_USER_FIRST = 16'h0008;
  localparam logic [15:0] SID_USER_LAST = 16'h07FF;

  // Link framing
  localparam logic [2:0] SPI_LAST_PHASE = 3'h7;
  localparam logic [2:0] QUAD_LAST_PHASE = 3'h1;
  localparam logic [11:0] SPI_READ_HDR = 12'h001;
  localparam logic [11:0] QUAD_READ_HDR = 12'h002;

  // Self-timed operations
  localparam int unsigned CORE_CLK_MHZ = 200;
  localparam int unsigned IDENT_PROG_TIME_NS = 50000;
  localparam int unsigned PAGE_PROG_TIME_NS = 1500000;
  localparam int unsigned IDENT_PROG_CYCLES =
    (IDENT_PROG_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned PAGE_PROG_CYCLES =
    (PAGE_PROG_TIME_NS * CORE_CLK_MHZ + 999) / 1000;

  // Arbitrary value standing in for the factory-unique identifier
  localparam logic [63:0] FACTORY_UID = 64'h0123_4567_89AB_CDEF;

  typedef struct packed {
    logic [STAT_W-1:0] status;
    logic [7:0] cfg;
    logic [MAP_W-1:0] map;
  } fsspc_view_s;

  typedef enum logic [1:0] {
    FSSPC_IDLE,
    FSSPC_COPY,
    FSSPC_WAIT
  } fsspc_state_e;
endpackage

// ===== logic/fsspc_top.sv
// Flash security identifier, status, config and protection command block
`timescale 1ns/1ps
module fsspc_top #(
  parameter int unsigned IDENT_PROG_CYC = fsspc_pkg::IDENT_PROG_CYCLES,
  parameter int unsigned PAGE_PROG_CYC = fsspc_pkg::PAGE_PROG_CYCLES
) (
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Serial link
  input wire logic link_sck_i,
  input wire logic link_cs_n_i,
  input wire logic [3:0] link_io_i,
  output logic [3:0] link_io_o,
  output logic [3:0] link_io_oe_o,
  // Mode strap
  input wire logic quad_mode_i,
  // Device state
  output logic busy_o,
  output logic write_latch_o,
  output logic [7:0] cfg_o,
  output logic [fsspc_pkg::MAP_W-1:0] protect_map_o,
  output logic [fsspc_pkg::MAP_W-1:0] nv_lock_o,
  output logic map_frozen_o,
  output logic sid_locked_o,
  // Identifier read-back
  input wire logic [fsspc_pkg::SID_ADDR_W-1:0] sid_rd_addr_i,
  output logic [7:0] sid_rd_data_o
);
  import fsspc_pkg::*;

  // Chunk of a word, MSB first; single mode drives the data-out line
  function automatic logic [3:0] pick(input logic [MAP_W-1:0] v,
                                      input int unsigned len,
                                      input logic [9:0] off,
                                      input logic quad);
    int unsigned top;
    top = len - 1 - int'(off);
    if (quad) begin
      pick = v[top -: 4];
    end else begin
      pick = {2'b00, v[top], 1'b0};
    end
  endfunction

  // ---------------- Link domain ----------------
  logic quad_s1;
  logic quad_s2;
  fsspc_view_s view_s1;
  fsspc_view_s view_s2;
  logic [2:0] phase;
  logic [11:0] nb;
  logic [7:0] byte_sh;
  logic [7:0] opcode;
  logic [15:0] addr;
  logic [11:0] data_cnt;
  logic [7:0] cfg_byte;
  logic [MAP_W-1:0] wide;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] buf_valid;
  logic [7:0] out_idx;
  logic map_over;
  logic [7:0] in_byte;
  logic byte_done;
  logic rd_active;
  logic [9:0] off;
  fsspc_view_s view;

  // Status and state words cross as levels; they only move between frames,
  // except the busy bit, which is a single bit and safe through two stages
  always_ff @(posedge link_sck_i) begin
    quad_s1 <= quad_mode_i;
    quad_s2 <= quad_s1;
    view_s1 <= view;
    view_s2 <= view_s1;
  end

  always_comb begin
    in_byte = quad_s2 ? {byte_sh[3:0], link_io_i} :
                        {byte_sh[6:0], link_io_i[0]};
    byte_done = phase == (quad_s2 ? QUAD_LAST_PHASE : SPI_LAST_PHASE);
  end

  // Framing counters restart whenever chip select is high
  always_ff @(posedge link_sck_i or posedge link_cs_n_i) begin
    if (link_cs_n_i) begin
      phase <= '0;
      nb <= '0;
      byte_sh <= '0;
    end else begin
      byte_sh <= in_byte;
      phase <= byte_done ? 3'h0 : phase + 3'h1;
      if (byte_done && nb != 12'hFFF) begin
        nb <= nb + 12'h001;
      end
    end
  end

  // Frame capture; left standing after the frame for the core to take
  always_ff @(posedge link_sck_i) begin
    if (byte_done) begin
      if (nb == 12'h000) begin
        opcode <= in_byte;
        data_cnt <= '0;
      end else if (opcode == CMD_PROGRAM_IDENTIFIER) begin
        if (nb == 12'h001) begin
          // Only a new program clears it, so a status poll cannot spoil a copy
          buf_valid <= '0;
          addr[15:8] <= in_byte;
        end else if (nb == 12'h002) begin
          addr[7:0] <= in_byte;
        end else begin
          // Index wraps within the page, later bytes overwrite earlier
          page_buf[addr[7:0] + data_cnt[7:0]] <= in_byte;
          buf_valid[addr[7:0] + data_cnt[7:0]] <= 1'b1;
          if (data_cnt != 12'hFFF) begin
            data_cnt <= data_cnt + 12'h001;
          end
        end
      end else begin
        if (data_cnt != 12'hFFF) begin
          data_cnt <= data_cnt + 12'h001;
        end
        if (opcode == CMD_WRITE_CONFIG && nb == CFG_DATA_BYTES) begin
          cfg_byte <= in_byte;
        end
        // Shifting keeps the last 18 bytes, MSB first
        wide <= {wide[MAP_W-9:0], in_byte};
      end
    end
  end

  always_comb begin
    rd_active = (opcode == CMD_READ_STATUS || opcode == CMD_READ_CONFIG ||
                 opcode == CMD_READ_PROTECT_MAP) &&
                nb >= (quad_s2 ? QUAD_READ_HDR : SPI_READ_HDR);
    off = quad_s2 ? {out_idx, 2'b00} : {2'b00, out_idx};
  end

  // Read data leaves on falling edges
  always_ff @(negedge link_sck_i or posedge link_cs_n_i) begin
    if (link_cs_n_i) begin
      link_io_o <= '0;
      link_io_oe_o <= '0;
      out_idx <= '0;
      map_over <= 1'b0;
    end else if (rd_active) begin
      link_io_oe_o <= quad_s2 ? 4'hF : 4'h2;
      out_idx <= out_idx + 8'h01;
      unique case (opcode)
        CMD_READ_PROTECT_MAP: begin
          link_io_o <= map_over ? 4'h0 :
                       pick(view_s2.map, MAP_W, off, quad_s2);
          if (int'(off) + (quad_s2 ? 4 : 1) >= MAP_W) begin
            map_over <= 1'b1;
          end
        end
        CMD_READ_CONFIG: begin
          link_io_o <= pick({{(MAP_W-8){1'b0}}, view_s2.cfg}, 8,
                            {7'h00, off[2:0]}, quad_s2);
        end
        default: begin
          // Status streams regardless of any running operation
          link_io_o <= pick({{(MAP_W-STAT_W){1'b0}}, view_s2.status},
                            STAT_W, {7'h00, off[2:0]}, quad_s2);
        end
      endcase
    end
  end

  // ---------------- Core domain ----------------
  logic cs_s1;
  logic cs_s2;
  logic cs_d;
  logic frame_end;
  fsspc_state_e state;
  logic [7:0] idx;
  logic [2:0] page;
  logic [31:0] timer;
  logic wel;
  logic [7:0] otp [SID_BYTES];
  logic [STAT_W-1:0] next_status;
  logic sid_ok;
  logic go_prog;
  logic go_lock;
  logic go_nv;
  logic go_cfg;
  logic go_map;
  logic go_freeze;

  // Captured frame is static while chip select stays high
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      cs_s1 <= link_cs_n_i;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
    end
  end

  always_comb begin
    // Commands other than status, config and map reads are ignored while busy
    frame_end = cs_s2 && !cs_d && state == FSSPC_IDLE;
    sid_ok = addr >= SID_USER_FIRST && addr <= SID_USER_LAST &&
             !sid_locked_o;
    go_prog = frame_end && wel && opcode == CMD_PROGRAM_IDENTIFIER &&
              sid_ok && data_cnt != 12'h000;
    go_lock = frame_end && wel && opcode == CMD_LOCKOUT_IDENTIFIER;
    go_nv = frame_end && wel && opcode == CMD_NONVOLATILE_LOCK_FREEZE &&
            data_cnt >= MAP_BYTES;
    go_cfg = frame_end && wel && opcode == CMD_WRITE_CONFIG &&
             data_cnt >= CFG_DATA_BYTES;
    go_map = frame_end && wel && opcode == CMD_WRITE_PROTECT_MAP &&
             !map_frozen_o && data_cnt >= MAP_BYTES;
    go_freeze = frame_end && wel && opcode == CMD_FREEZE_PROTECT_MAP;
    next_status = '0;
    next_status[STAT_BUSY_BIT] = busy_o;
    next_status[STAT_WEL_BIT] = wel;
  end

  // Self-timed operation sequencing
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= FSSPC_IDLE;
      busy_o <= 1'b0;
      idx <= '0;
      page <= '0;
      timer <= '0;
    end else begin
      unique case (state)
        FSSPC_IDLE: begin
          if (go_prog) begin
            state <= FSSPC_COPY;
            busy_o <= 1'b1;
            idx <= '0;
            page <= addr[10:8];
          end else if (go_lock || go_nv) begin
            state <= FSSPC_WAIT;
            busy_o <= 1'b1;
            timer <= go_nv ? 32'(PAGE_PROG_CYC - 1) :
                             32'(IDENT_PROG_CYC - 1);
          end
        end
        FSSPC_COPY: begin
          idx <= idx + 8'h01;
          if (idx == 8'hFF) begin
            state <= FSSPC_WAIT;
            timer <= 32'(IDENT_PROG_CYC - 1);
          end
        end
        default: begin
          if (timer == 32'h0000_0000) begin
            state <= FSSPC_IDLE;
            busy_o <= 1'b0;
          end else begin
            timer <= timer - 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // Write latch: every accepted write consumes it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wel <= 1'b0;
    end else if (frame_end && opcode == CMD_SET_WRITE_LATCH) begin
      wel <= 1'b1;
    end else if (frame_end && opcode == CMD_CLEAR_WRITE_LATCH) begin
      wel <= 1'b0;
    end else if (go_prog || go_lock || go_nv || go_cfg || go_map ||
                 go_freeze) begin
      wel <= 1'b0;
    end
  end

  // Configuration and protection state; reset stands for power-up
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_o <= CFG_RESET;
      protect_map_o <= MAP_RESET;
      nv_lock_o <= '0;
      map_frozen_o <= 1'b0;
      sid_locked_o <= 1'b0;
    end else begin
      if (go_cfg) begin
        cfg_o <= cfg_byte;
      end
      if (go_map) begin
        // Bits that are locked down keep their value
        protect_map_o <= (protect_map_o & nv_lock_o) |
                         (wide & ~nv_lock_o);
      end
      if (go_nv) begin
        nv_lock_o <= nv_lock_o | wide;
      end
      if (go_freeze) begin
        map_frozen_o <= 1'b1;
      end
      if (go_lock) begin
        sid_locked_o <= 1'b1;
      end
    end
  end

  // Identifier array; bytes landing on the factory range are skipped
  always_ff @(posedge core_clk_i) begin
    if (state == FSSPC_COPY && buf_valid[idx] &&
        {page, idx} >= SID_USER_FIRST[SID_ADDR_W-1:0]) begin
      otp[{page, idx}] <= page_buf[idx];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      write_latch_o <= 1'b0;
      view <= '0;
      sid_rd_data_o <= '0;
    end else begin
      write_latch_o <= wel;
      view.status <= next_status;
      view.cfg <= cfg_o;
      view.map <= protect_map_o;
      if (sid_rd_addr_i < SID_USER_FIRST[SID_ADDR_W-1:0]) begin
        sid_rd_data_o <= FACTORY_UID[{sid_rd_addr_i[2:0], 3'b000} +: 8];
      end else begin
        sid_rd_data_o <= otp[sid_rd_addr_i];
      end
    end
  end
endmodule

// ===== tb/fsspc_checker.sv
// Assertion checker on the ports of the command block
`timescale 1ns/1ps
module fsspc_checker #(
  parameter int unsigned IDENT_PROG_CYC = 20,
  parameter int unsigned PAGE_PROG_CYC = 30
) (
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Device state
  input wire logic busy_o,
  input wire logic write_latch_o,
  input wire logic [7:0] cfg_o,
  input wire logic [fsspc_pkg::MAP_W-1:0] protect_map_o,
  input wire logic [fsspc_pkg::MAP_W-1:0] nv_lock_o,
  input wire logic map_frozen_o,
  input wire logic sid_locked_o
);
  import fsspc_pkg::*;
  // Loose bound: covers the longest self-timed run with slack
  localparam int unsigned BUSY_MAX = 264 + IDENT_PROG_CYC + PAGE_PROG_CYC;
  int unsigned busy_run;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_busy_two;
    busy_o ##1 busy_o;
  endsequence
  sequence s_busy_end;
    busy_o ##1 !busy_o;
  endsequence
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !busy_o) begin
      busy_run <= 0;
    end else begin
      busy_run <= busy_run + 1;
    end
  end
  chk_reset_state: assert property (disable iff (1'b0)
    rst_i |=> !busy_o && !write_latch_o && !map_frozen_o && nv_lock_o == '0)
    else $error("state not cleared by reset");
  chk_freeze_sticky: assert property (map_frozen_o |=> map_frozen_o)
    else $error("map freeze dropped");
  chk_frozen_map: assert property (
    map_frozen_o ##1 map_frozen_o |-> $stable(protect_map_o))
    else $error("frozen map changed");
  chk_lock_sticky: assert property (sid_locked_o |=> sid_locked_o)
    else $error("identifier lock dropped");
  chk_lock_busy: assert property ($rose(sid_locked_o) |-> ##[0:2] busy_o)
    else $error("lockout without busy");
  chk_nv_oneway: assert property (
    1'b1 |=> ($past(nv_lock_o) & ~nv_lock_o) == '0)
    else $error("lock-down bit cleared");
  chk_locked_bits: assert property (1'b1 |=>
    ((protect_map_o ^ $past(protect_map_o)) & $past(nv_lock_o)) == '0)
    else $error("locked map bit changed");
  chk_busy_bound: assert property (busy_run < BUSY_MAX)
    else $error("busy never ends");
  chk_busy_cfg: assert property (s_busy_two |-> $stable(cfg_o))
    else $error("config changed while busy");
  chk_busy_latch: assert property (s_busy_end |-> !write_latch_o)
    else $error("write latch set after write");
endmodule

// ===== tb/fsspc_host.sv
// Behavioural host controller driving the serial link
`timescale 1ns/1ps
module fsspc_host (
  // Serial link
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  output logic quad_o,
  input wire logic [3:0] io_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h5;
    quad_o = 1'b0;
  end
  task automatic tick(input logic [3:0] d, output logic [3:0] q);
    sck_o = 1'b0;
    io_o = d;
    #80;
    q = io_i;
    sck_o = 1'b1;
    #80;
  endtask
  // Mode is settled by two clocks before the next frame
  task automatic mode(input logic m);
    logic [3:0] q;
    quad_o = m;
    tick(io_o, q);
    tick(io_o, q);
    sck_o = 1'b0;
  endtask
  task automatic frame(input logic [7:0] b[$], input int nbit,
                       output logic [159:0] rd);
    logic [3:0] q;
    rd = '0;
    cs_n_o = 1'b0;
    #43;
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k -= quad_o ? 4 : 1) begin
        tick(quad_o ? b[i][k-:4] : {3'h0, b[i][k]}, q);
      end
    end
    for (int n = 0; n < nbit; n += quad_o ? 4 : 1) begin
      tick(~io_o, q);
      rd = quad_o ? {rd[155:0], q} : {rd[158:0], q[1]};
    end
    sck_o = 1'b0;
    #40;
    cs_n_o = 1'b1;
    io_o = ~io_o;
    #80;
  endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the flash command block
`timescale 1ns/1ps
module tb_top;
  import fsspc_pkg::*;
  localparam int unsigned IDENT_PROG_CYC = 600;
  localparam int unsigned PAGE_PROG_CYC = 400;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sck, cs_n, quad, busy, latch, frozen, locked, saw_busy;
  logic [3:0] hio, io_o, oe, wire_io;
  logic [7:0] cfg, sid_data;
  logic [MAP_W-1:0] map, nv, pm, nvv;
  logic [SID_ADDR_W-1:0] sid_addr = '0;
  logic [159:0] rd;
  logic [159:0] seen_q[$], exp_q[$];
  int failures = 0, cmp_count = 0, cyc = 0;
  int seed = 32'h8947;
  initial forever #2.5 core_clk_i = ~core_clk_i;
  assign wire_io = (oe & io_o) | (~oe & hio);
  fsspc_host fsspc_host_inst (.sck_o(sck), .cs_n_o(cs_n), .io_o(hio),
    .quad_o(quad), .io_i(wire_io));
  fsspc_top #(.IDENT_PROG_CYC(IDENT_PROG_CYC),
    .PAGE_PROG_CYC(PAGE_PROG_CYC)) fsspc_top_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .link_sck_i(sck),
    .link_cs_n_i(cs_n), .link_io_i(wire_io), .link_io_o(io_o),
    .link_io_oe_o(oe), .quad_mode_i(quad), .busy_o(busy),
    .write_latch_o(latch), .cfg_o(cfg), .protect_map_o(map),
    .nv_lock_o(nv), .map_frozen_o(frozen), .sid_locked_o(locked),
    .sid_rd_addr_i(sid_addr), .sid_rd_data_o(sid_data));
  task automatic check(input logic [159:0] s, input logic [159:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic ck(input logic [159:0] s, input logic [159:0] e);
    exp_q.push_back(e);
    seen_q.push_back(s);
  endtask
  always @(posedge core_clk_i) begin
    while (seen_q.size() > 0) begin
      check(seen_q.pop_front(), exp_q.pop_front());
    end
  end
  always @(posedge core_clk_i) begin
    if (busy) saw_busy <= 1'b1;
  end
  task automatic wrap_up;
    #1;
    while (seen_q.size() > 0) begin
      check(seen_q.pop_front(), exp_q.pop_front());
    end
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      wrap_up;
    end
  end
  task automatic cmd(input logic [7:0] b[$], input int n = 0);
    fsspc_host_inst.frame(b, n, rd);
    repeat (8) @(negedge core_clk_i);
  endtask
  task automatic poll;
    for (int i = 0; i < 40; i++) begin
      cmd('{CMD_READ_STATUS}, 8);
      if (rd[0] === 1'b0) break;
    end
    ck(busy, 1'b0);
  endtask
  task automatic mapcmd(input logic [7:0] op, input logic [143:0] v);
    logic [7:0] b[$];
    b = '{op};
    for (int i = 17; i >= 0; i--) b.push_back(v[i*8+:8]);
    cmd('{CMD_SET_WRITE_LATCH});
    saw_busy = 1'b0;
    cmd(b);
  endtask
  task automatic security_identifier(input logic [10:0] a, input logic [7:0] e);
    @(negedge core_clk_i);
    sid_addr = a;
    repeat (2) @(negedge core_clk_i);
    ck(sid_data, e);
  endtask
  task automatic reset_dut;
    @(negedge core_clk_i);
    rst_i = 1'b1;
    repeat (12) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
  endtask
  initial begin
    saw_busy = 1'b0;
    reset_dut;
    ck({busy, latch, frozen, locked, cfg, map | nv}, '0);
    cmd('{CMD_SET_WRITE_LATCH});
    cmd('{CMD_READ_STATUS}, 16);
    ck(rd[15:0], 16'h0202);
    cmd('{CMD_CLEAR_WRITE_LATCH});
    cmd('{CMD_READ_STATUS}, 8);
    ck(rd[7:0], 8'h00);
    pm = 144'({$random(seed), $random(seed), $random(seed),
      $random(seed), $random(seed)});
    nvv = ~pm ^ 144'({$random(seed), $random(seed), $random(seed),
      $random(seed), $random(seed)});
    cmd('{CMD_WRITE_CONFIG, 8'hFF, pm[7:0]});
    ck(cfg, CFG_RESET);
    cmd('{CMD_SET_WRITE_LATCH});
    cmd('{CMD_WRITE_CONFIG, ~pm[7:0], pm[7:0]});
    ck(cfg, pm[7:0]);
    fsspc_host_inst.mode(1'b1);
    cmd('{CMD_READ_CONFIG, 8'h00}, 16);
    ck(rd[15:0], {2{pm[7:0]}});
    fsspc_host_inst.mode(1'b0);
    $display("test status and config done");
    mapcmd(CMD_WRITE_PROTECT_MAP, pm);
    ck(map, pm);
    cmd('{CMD_READ_PROTECT_MAP}, 152);
    ck(rd[151:0], {pm, 8'h00});
    mapcmd(CMD_NONVOLATILE_LOCK_FREEZE, nvv);
    cmd('{CMD_SET_WRITE_LATCH});
    poll;
    ck({saw_busy, latch, nv}, {2'b10, nvv});
    mapcmd(CMD_WRITE_PROTECT_MAP, '0);
    ck(map, pm & nvv);
    cmd('{CMD_SET_WRITE_LATCH});
    cmd('{CMD_FREEZE_PROTECT_MAP});
    ck(frozen, 1'b1);
    mapcmd(CMD_WRITE_PROTECT_MAP, ~pm);
    ck(map, pm & nvv);
    reset_dut;
    ck({frozen, map}, '0);
    $display("test protection map done");
    cmd('{CMD_SET_WRITE_LATCH});
    cmd('{CMD_PROGRAM_IDENTIFIER, 8'h00, 8'h04, 8'h11});
    ck({busy, latch}, 2'b01);
    saw_busy = 1'b0;
    cmd('{CMD_PROGRAM_IDENTIFIER, 8'h01, 8'hFE, pm[31:24], pm[23:16],
      pm[15:8], pm[7:0]});
    cmd('{CMD_READ_STATUS}, 8);
    ck(rd[0], 1'b1);
    poll;
    ck(saw_busy, 1'b1);
    security_identifier(11'h1FE, pm[31:24]);
    security_identifier(11'h1FF, pm[23:16]);
    security_identifier(11'h100, pm[15:8]);
    security_identifier(11'h101, pm[7:0]);
    cmd('{CMD_SET_WRITE_LATCH});
    cmd('{CMD_LOCKOUT_IDENTIFIER});
    ck({locked, busy}, 2'b11);
    poll;
    cmd('{CMD_SET_WRITE_LATCH});
    cmd('{CMD_PROGRAM_IDENTIFIER, 8'h01, 8'h08, 8'h5A});
    ck({busy, latch}, 2'b01);
    $display("test identifier done");
    wrap_up;
  end
endmodule
bind fsspc_top fsspc_checker #(.IDENT_PROG_CYC(IDENT_PROG_CYC),
  .PAGE_PROG_CYC(PAGE_PROG_CYC)) fsspc_checker_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .busy_o(busy_o),
  .write_latch_o(write_latch_o), .cfg_o(cfg_o),
  .protect_map_o(protect_map_o), .nv_lock_o(nv_lock_o),
  .map_frozen_o(map_frozen_o), .sid_locked_o(sid_locked_o));
